// ===== rtl/scrc_pkg.sv
// Package for the slope compensation ramp configuration block.
// Assumes a 125 MHz core clock and a command-coded register port.
package scrc_pkg;
    localparam logic [7:0] SCRC_OFS_RAMP_6P = 8'hd1;
    localparam logic [7:0] SCRC_OFS_SLEW_5P = 8'hd2;
    localparam logic [7:0] SCRC_OFS_RAMP_5P = 8'hd3;
    localparam logic [7:0] SCRC_OFS_SLEW_4P = 8'hd4;
    localparam int SCRC_CNT_LSB = 0;
    localparam int SCRC_CNT_MSB = 7;
    localparam int SCRC_CUR_LSB = 0;
    localparam int SCRC_CUR_MSB = 5;
    localparam int SCRC_CAP_LSB = 6;
    localparam int SCRC_CAP_MSB = 8;
    localparam logic [7:0] SCRC_RAMP_RST = 8'h00;
    localparam logic [2:0] SCRC_CAP_RST = 3'h0;
    localparam logic [5:0] SCRC_CUR_RST = 6'h00;
    localparam int SCRC_CLK_PERIOD_PS = 8000;
    localparam int SCRC_STEP_PS = 5000;
    localparam logic [2:0] SCRC_PH_FOUR = 3'h4;
    localparam logic [2:0] SCRC_PH_FIVE = 3'h5;
    localparam logic [2:0] SCRC_PH_SIX = 3'h6;

    typedef struct packed {
        logic [2:0] cap;
        logic [5:0] cur;
    } scrc_slew_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } scrc_req_s;

    typedef enum logic [1:0] {
        SCRC_IDLE = 2'b00,
        SCRC_BLANK = 2'b01,
        SCRC_RAMP = 2'b10,
        SCRC_HOLD = 2'b11
    } scrc_state_e;
endpackage

// ===== rtl/scrc_ramp_config.sv
// Slope compensation registers and ramp timer for four to six phase operation.
// Assumes the phase sequencer marks each slot start and the end of blanking.
`timescale 1ns/1ps
// Contract
// - Ramp-time registers drop writes to bits 15:8 and read them as zero.
// - Slew registers drop writes to bits 15:9 and read them as zero.
// - Six-phase ramp time is an 8-bit count, 5 ns per step.
// - Five-phase ramp time has its own 8-bit count, 5 ns per step.
// - Expired ramp timer stops charge current and holds slope voltage.
// - Slew registers carry a 3-bit capacitor code in bits 8:6.
// - Slew registers carry a 6-bit current code in bits 5:0.
// - Five-phase slew settings apply while five phases run.
// - Four-phase slew settings apply while four phases run.
// - Period and blanking timing come from frequency and blanking registers.
module scrc_ramp_config (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire scrc_pkg::scrc_req_s REG_REQ,
    output logic [15:0] REG_RDATA,
    output logic REG_HIT,
    input wire logic [2:0] PHASE_COUNT,
    input wire logic SLOT_START,
    input wire logic BLANK_DONE,
    input wire scrc_pkg::scrc_slew_s SLEW_OTHER,
    input wire logic [7:0] RAMP_OTHER,
    output scrc_pkg::scrc_slew_s SLEW_ACTIVE,
    output logic RAMP_CHARGE_EN,
    output logic SLOPE_HOLD
);
    import scrc_pkg::*;

    // Step of 5 ns against 8 ns clock; a least time, so round up
    localparam int STEP_NUM = SCRC_STEP_PS;
    localparam int STEP_DEN = SCRC_CLK_PERIOD_PS;

    logic [7:0] ramp6_reg, ramp6_next;
    logic [7:0] ramp5_reg, ramp5_next;
    scrc_slew_s slew5_reg, slew5_next;
    scrc_slew_s slew4_reg, slew4_next;
    logic [15:0] rdata_reg, rdata_next;
    logic hit_reg, hit_next;

    always_comb begin
        ramp6_next = ramp6_reg;
        ramp5_next = ramp5_reg;
        slew5_next = slew5_reg;
        slew4_next = slew4_reg;
        if (REG_REQ.wr) begin
            unique case (REG_REQ.cmd)
                SCRC_OFS_RAMP_6P: ramp6_next = REG_REQ.wdata[SCRC_CNT_MSB:SCRC_CNT_LSB];
                SCRC_OFS_RAMP_5P: ramp5_next = REG_REQ.wdata[SCRC_CNT_MSB:SCRC_CNT_LSB];
                SCRC_OFS_SLEW_5P: begin
                    slew5_next.cap = REG_REQ.wdata[SCRC_CAP_MSB:SCRC_CAP_LSB];
                    slew5_next.cur = REG_REQ.wdata[SCRC_CUR_MSB:SCRC_CUR_LSB];
                end
                SCRC_OFS_SLEW_4P: begin
                    slew4_next.cap = REG_REQ.wdata[SCRC_CAP_MSB:SCRC_CAP_LSB];
                    slew4_next.cur = REG_REQ.wdata[SCRC_CUR_MSB:SCRC_CUR_LSB];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        hit_next = 1'b0;
        if (REG_REQ.rd) begin
            hit_next = 1'b1;
            unique case (REG_REQ.cmd)
                SCRC_OFS_RAMP_6P: rdata_next = {8'h00, ramp6_reg};
                SCRC_OFS_RAMP_5P: rdata_next = {8'h00, ramp5_reg};
                SCRC_OFS_SLEW_5P: rdata_next = {7'h00, slew5_reg};
                SCRC_OFS_SLEW_4P: rdata_next = {7'h00, slew4_reg};
                default: hit_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ramp6_reg <= SCRC_RAMP_RST;
            ramp5_reg <= SCRC_RAMP_RST;
            slew5_reg <= '{cap: SCRC_CAP_RST, cur: SCRC_CUR_RST};
            slew4_reg <= '{cap: SCRC_CAP_RST, cur: SCRC_CUR_RST};
            rdata_reg <= 16'h0000;
            hit_reg <= 1'b0;
        end else begin
            ramp6_reg <= ramp6_next;
            ramp5_reg <= ramp5_next;
            slew5_reg <= slew5_next;
            slew4_reg <= slew4_next;
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
        end
    end

    assign REG_RDATA = rdata_reg;
    assign REG_HIT = hit_reg;

    // Setting selection per active phase count
    scrc_slew_s slew_sel;
    logic [7:0] count_sel;
    always_comb begin
        unique case (PHASE_COUNT)
            SCRC_PH_FIVE: slew_sel = slew5_reg;
            SCRC_PH_FOUR: slew_sel = slew4_reg;
            default: slew_sel = SLEW_OTHER;
        endcase
        unique case (PHASE_COUNT)
            SCRC_PH_SIX: count_sel = ramp6_reg;
            SCRC_PH_FIVE: count_sel = ramp5_reg;
            default: count_sel = RAMP_OTHER;
        endcase
    end

    // Ramp timer: counts 5 ns steps as a ps accumulator to stay exact at 8 ns clock
    scrc_state_e state_reg, state_next;
    // 21 bits: a full count of 255 steps is past 2^20 ps
    logic [20:0] limit_reg, limit_next;
    logic [20:0] elapsed_reg, elapsed_next;
    scrc_slew_s slew_out_reg, slew_out_next;
    logic [20:0] limit_ps;

    assign limit_ps = 21'(count_sel) * 21'(STEP_NUM);

    always_comb begin
        state_next = state_reg;
        limit_next = limit_reg;
        elapsed_next = elapsed_reg;
        slew_out_next = slew_sel;
        if (SLOT_START) begin
            state_next = SCRC_BLANK;
            limit_next = limit_ps;
            elapsed_next = 21'h000000;
        end else begin
            unique case (state_reg)
                SCRC_IDLE: ;
                SCRC_BLANK: begin
                    // Blanking length comes from the sequencer's blanking register
                    if (BLANK_DONE) begin
                        state_next = (limit_reg == 21'h000000) ? SCRC_HOLD : SCRC_RAMP;
                    end
                end
                SCRC_RAMP: begin
                    // Whole ps per clock; a partial step still ends the ramp late, not early
                    elapsed_next = elapsed_reg + 21'(STEP_DEN);
                    if (elapsed_next >= limit_reg) begin
                        state_next = SCRC_HOLD;
                    end
                end
                SCRC_HOLD: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state_reg <= SCRC_IDLE;
            limit_reg <= 21'h000000;
            elapsed_reg <= 21'h000000;
            slew_out_reg <= '{cap: SCRC_CAP_RST, cur: SCRC_CUR_RST};
        end else begin
            state_reg <= state_next;
            limit_reg <= limit_next;
            elapsed_reg <= elapsed_next;
            slew_out_reg <= slew_out_next;
        end
    end

    assign SLEW_ACTIVE = slew_out_reg;
    assign RAMP_CHARGE_EN = (state_reg == SCRC_RAMP);
    assign SLOPE_HOLD = (state_reg == SCRC_HOLD);
endmodule

// ===== test/scrc_ramp_config_asserts.sv
// Checker for the slope ramp register block.
// Assumes binding onto the block's top module.
`timescale 1ns/1ps
module scrc_ramp_config_asserts (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire scrc_pkg::scrc_req_s REG_REQ,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_HIT,
    input wire logic SLOT_START,
    input wire logic BLANK_DONE,
    input wire logic RAMP_CHARGE_EN,
    input wire logic SLOPE_HOLD
);
    import scrc_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_rd; REG_REQ.rd && REG_REQ.cmd inside {[8'hd1:8'hd4]}; endsequence
    // A second slot start in the blanking cycle restarts the slot
    sequence s_arm; SLOT_START ##1 (BLANK_DONE && !SLOT_START); endsequence
    property p_hit; s_rd |=> REG_HIT; endproperty
    property p_quiet; !REG_REQ.rd |=> !REG_HIT && REG_RDATA == 16'h0000; endproperty
    property p_rsv_ramp; REG_HIT && $past(REG_REQ.cmd[0]) |-> REG_RDATA[15:8] == 8'h00; endproperty
    property p_rsv_slew; REG_HIT |-> REG_RDATA[15:9] == 7'h00; endproperty
    property p_slot; SLOT_START |=> !RAMP_CHARGE_EN && !SLOPE_HOLD; endproperty
    property p_arm; s_arm |=> RAMP_CHARGE_EN || SLOPE_HOLD; endproperty
    property p_stop; $fell(RAMP_CHARGE_EN) && !$past(SLOT_START) |-> SLOPE_HOLD; endproperty
    property p_hold; SLOPE_HOLD && !SLOT_START |=> SLOPE_HOLD; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    a_quiet: assert property (p_quiet) else $error("stray read data");
    a_rsv_ramp: assert property (p_rsv_ramp) else $error("ramp upper bits");
    a_rsv_slew: assert property (p_rsv_slew) else $error("slew upper bits");
    a_slot: assert property (p_slot) else $error("slot not blanked");
    a_arm: assert property (p_arm) else $error("ramp not started");
    a_stop: assert property (p_stop) else $error("no hold at stop");
    a_hold: assert property (p_hold) else $error("hold lost");
endmodule
bind scrc_ramp_config scrc_ramp_config_asserts i_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .SLOT_START(SLOT_START),
    .BLANK_DONE(BLANK_DONE), .RAMP_CHARGE_EN(RAMP_CHARGE_EN), .SLOPE_HOLD(SLOPE_HOLD));

// ===== test/scrc_ramp_config_bench.sv
// Self-checking bench for the slope ramp register block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module scrc_ramp_config_bench;
    import scrc_pkg::*;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    scrc_req_s REG_REQ = '0;
    logic [2:0] PHASE_COUNT = 3'h0;
    logic SLOT_START = 1'b0;
    logic BLANK_DONE = 1'b0;
    scrc_slew_s SLEW_OTHER = '0;
    logic [7:0] RAMP_OTHER = 8'h00;
    logic [15:0] REG_RDATA;
    logic REG_HIT;
    scrc_slew_s SLEW_ACTIVE;
    logic RAMP_CHARGE_EN;
    logic SLOPE_HOLD;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n;
    logic [15:0] q[$];
    logic [15:0] w[4];
    logic [31:0] seed = 32'd71;
    logic [7:0] c;
    scrc_ramp_config i_scrc_ramp_config (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
        .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT),
        .PHASE_COUNT(PHASE_COUNT), .SLOT_START(SLOT_START), .BLANK_DONE(BLANK_DONE),
        .SLEW_OTHER(SLEW_OTHER), .RAMP_OTHER(RAMP_OTHER), .SLEW_ACTIVE(SLEW_ACTIVE),
        .RAMP_CHARGE_EN(RAMP_CHARGE_EN), .SLOPE_HOLD(SLOPE_HOLD));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic wr, input logic [7:0] cmd, input logic [15:0] d);
        @(posedge REF_CLK);
        REG_REQ <= '{wr, !wr, cmd, d};
        @(posedge REF_CLK);
        REG_REQ <= '0;
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial forever #4 REF_CLK = ~REF_CLK;
    // An empty queue forces a mismatch on a stray hit
    always @(posedge REF_CLK) if (REG_HIT === 1'b1)
        chk(REG_RDATA, q.size() ? q.pop_front() : ~REG_RDATA);
    initial begin
        repeat (5000) @(posedge REF_CLK);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        foreach (w[i]) begin
            seed = xs(seed);
            w[i] = seed[15:0];
            req(1'b1, 8'hd1 + 8'(i), w[i]);
        end
        req(1'b0, 8'hd5, 16'h0000);
        @(negedge REF_CLK);
        chk({15'h0, REG_HIT}, 16'h0000);
        foreach (w[i]) begin
            q.push_back(w[i] & (i[0] ? 16'h01ff : 16'h00ff));
            req(1'b0, 8'hd1 + 8'(i), 16'h0000);
        end
        @(posedge REF_CLK);
        SLEW_OTHER <= scrc_slew_s'(seed[24:16]);
        RAMP_OTHER <= seed[31:24];
        for (int p = 4; p <= 6; p++) begin
            @(posedge REF_CLK);
            PHASE_COUNT <= 3'(p);
            repeat (2) @(posedge REF_CLK);
            @(negedge REF_CLK);
            chk(16'(SLEW_ACTIVE), p == 4 ? w[3] & 16'h01ff
                : p == 5 ? w[1] & 16'h01ff : 16'(SLEW_OTHER));
            c = p == 6 ? w[0][7:0] : p == 5 ? w[2][7:0] : RAMP_OTHER;
            @(posedge REF_CLK);
            SLOT_START <= 1'b1;
            @(posedge REF_CLK);
            SLOT_START <= 1'b0;
            BLANK_DONE <= 1'b1;
            @(posedge REF_CLK);
            BLANK_DONE <= 1'b0;
            n = 0;
            @(negedge REF_CLK);
            while (RAMP_CHARGE_EN === 1'b1 && n < 300) begin
                n++;
                @(negedge REF_CLK);
            end
            chk(16'(n), 16'((32'(c) * 5 + 7) / 8));
            chk({15'h0, SLOPE_HOLD}, 16'h0001);
        end
        chk(16'(q.size()), 16'h0000);
        end_of_test();
    end
endmodule
